// ==== common/dio_port_pkg.sv ====
// Shared constants and carrier types for the digital I/O controller bus port
package dio_port_pkg;
    localparam int DATA_W = 8;
    // Command byte field positions
    localparam int CMD_INT_LO = 0;
    localparam int CMD_INT_HI = 1;
    localparam int CMD_ADDRESSED_ACCESS_BIT_BIT = 4;
    localparam int CMD_SEQ_BIT = 5;
    localparam int CMD_WRT_BIT = 6;
    localparam int CMD_RD_BIT = 7;
    // Address register field positions
    localparam int ADDR_MOD_LO = 0;
    localparam int ADDR_MOD_HI = 3;
    localparam int ADDR_GROUP_BIT = 4;
    localparam int ADDR_BYTE_LO = 5;
    localparam int ADDR_BYTE_HI = 7;
    // Reset values
    localparam logic [7:0] CMD_RESET = 8'h00;
    localparam logic [7:0] ADDR_RESET = 8'h00;
    localparam logic [7:0] DATA_RESET = 8'h00;
    // Delay from output latch to data clock, and acknowledge wait
    localparam int CLK_MHZ = 200;
    localparam int CLK_DELAY_NS = 20;
    localparam int CLK_DELAY_CYC = (CLK_DELAY_NS * CLK_MHZ + 999) / 1000;
    localparam int ACK_WAIT_NS = 500;
    localparam int ACK_WAIT_CYC = (ACK_WAIT_NS * CLK_MHZ) / 1000;

    typedef struct packed {
        logic address_strobe;
        logic command_strobe;
        logic write_data_strobe;
        logic read_data_strobe;
    } strobes_s;

    typedef struct packed {
        logic [1:0] int_ctrl;
        logic addressed_access_bit;
        logic incrementing_access_bit;
        logic output_direction_bit;
        logic read_bit;
    } mode_s;

    typedef struct packed {
        logic group_one_clock;
        logic group_two_clock;
        logic [2:0] byte_select;
        logic [3:0] module_select;
        logic output_select;
        logic input_select;
    } module_sel_s;
endpackage

// ==== logic/pin_sync.sv ====
// Three-stage input synchroniser; output changes once stages two and three agree
`timescale 1ns/100ps
module pin_sync import dio_port_pkg::*; #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] s1_reg, s2_reg, s3_reg, q_reg, q_next;

    always_comb begin
        q_next = q_reg;
        for (int i = 0; i < W; i++) begin
            if (s2_reg[i] == s3_reg[i]) begin
                q_next[i] = s3_reg[i];
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
            q_reg <= '0;
        end else begin
            s1_reg <= d;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            q_reg <= q_next;
        end
    end

    assign q = q_reg;
endmodule

// ==== logic/dio_bus_port.sv ====
// Processor-side bus port of the digital I/O controller
// Summary of operation
// - Random output: first data strobe carries address, next carries output byte.
// - Sequential output: after setup every data strobe carries only output bytes.
// - Address strobe matching the jumpered address returns sync, sets selected flag.
// - Selected flag holds until a foreign address; only then commands/data accepted.
// - Command strobe latches byte: interrupt bits 0-1, random 4, sequential 5, write 6, read 7.
// - After accepting a command strobe, return sync.
// - First data strobe after a command loads the address register and returns sync.
// - Write: later data strobes carry output data; read: read strobes follow.
// - Module chosen by address bits 0-3 plus write/read flag from command bits 6-7.
// - No acknowledge sets the device-unavailable flag.
// - Output data strobe returns sync; when set up for write, latch and drive data.
// - Each output latch gives one delayed data clock pulse gated by write mode.
// - Address bit 4 steers the clock to group one or two; bits 5-7 pick the byte.
// - Mode and direction hold until a new command byte or reset.
// - Sequential mode increments the address register after each transfer.
`timescale 1ns/100ps
module dio_bus_port import dio_port_pkg::*; #(
    parameter logic [7:0] DEVICE_ADDRESS = 8'h01
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire strobes_s strobes_n,
    input wire logic [DATA_W-1:0] bus_data_lines,
    input wire logic module_acknowledge_n,
    output logic sync_reply_n,
    output logic selected_flag,
    output logic address_loaded_flop,
    output logic device_unavailable_flag,
    output mode_s mode,
    output logic [DATA_W-1:0] address_out,
    output logic [DATA_W-1:0] output_data,
    output module_sel_s module_sel,
    output logic module_data_clock
);
    typedef enum {IDLE, ACTIVE, HOLD} bus_state_e;

    logic rst_m_reg, rst_s_reg, srst_n;
    logic [3:0] strb_sync;
    logic ack_sync_n;
    logic [DATA_W-1:0] dal_s1_reg, dal_s2_reg;

    bus_state_e state_reg, state_next;
    logic sel_reg, sel_next;
    logic loaded_reg, loaded_next;
    logic du_reg, du_next;
    logic [7:0] cmd_reg, cmd_next;
    logic [7:0] addr_reg, addr_next;
    logic [7:0] data_reg, data_next;
    logic latch_reg, latch_next;
    logic [7:0] dly_reg, dly_next;
    logic clk_pulse_reg, clk_pulse_next;
    logic [7:0] ack_cnt_reg, ack_cnt_next;
    logic ack_wait_reg, ack_wait_next;
    logic sync_reg, sync_next;

    // Reset release through two flops
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_m_reg <= 1'b0;
            rst_s_reg <= 1'b0;
        end else begin
            rst_m_reg <= 1'b1;
            rst_s_reg <= rst_m_reg;
        end
    end
    assign srst_n = rst_s_reg;

    // Strobes and acknowledge are active low pins; invert before syncing
    pin_sync #(.W(5)) u_sync (
        .clk(clk),
        .rst_n(srst_n),
        .d({~strobes_n.address_strobe, ~strobes_n.command_strobe,
            ~strobes_n.write_data_strobe, ~strobes_n.read_data_strobe,
            ~module_acknowledge_n}),
        .q({strb_sync, ack_sync_n})
    );

    // Data lines settle before strobes; two stages, so data is ready two cycles before the synced strobes
    always_ff @(posedge clk or negedge srst_n) begin
        if (!srst_n) begin
            dal_s1_reg <= '0;
            dal_s2_reg <= '0;
        end else begin
            dal_s1_reg <= bus_data_lines;
            dal_s2_reg <= dal_s1_reg;
        end
    end

    function automatic logic one_hot4(input logic [3:0] v);
        return v == 4'b1000 || v == 4'b0100 || v == 4'b0010 || v == 4'b0001;
    endfunction

    logic adr_s, cmd_s, wda_s, rda_s, any_s;
    assign adr_s = strb_sync[3];
    assign cmd_s = strb_sync[2];
    assign wda_s = strb_sync[1];
    assign rda_s = strb_sync[0];
    assign any_s = |strb_sync;

    always_comb begin
        state_next = state_reg;
        sel_next = sel_reg;
        loaded_next = loaded_reg;
        du_next = du_reg;
        cmd_next = cmd_reg;
        addr_next = addr_reg;
        data_next = data_reg;
        latch_next = 1'b0;
        sync_next = sync_reg;
        ack_wait_next = ack_wait_reg;
        ack_cnt_next = ack_cnt_reg;
        case (state_reg)
            IDLE: begin
                if (one_hot4(strb_sync)) begin
                    state_next = HOLD;
                    if (adr_s) begin
                        if (dal_s2_reg == DEVICE_ADDRESS) begin
                            sel_next = 1'b1;
                            sync_next = 1'b1;
                        end else begin
                            sel_next = 1'b0;
                        end
                    end else if (sel_reg) begin
                        sync_next = 1'b1;
                        if (cmd_s) begin
                            cmd_next = dal_s2_reg;
                            loaded_next = 1'b0;
                        end else if (wda_s && !loaded_reg) begin
                            addr_next = dal_s2_reg;
                            loaded_next = 1'b1;
                            ack_wait_next = 1'b1;
                            ack_cnt_next = '0;
                            du_next = 1'b0;
                        end else if (wda_s && cmd_reg[CMD_WRT_BIT]) begin
                            data_next = dal_s2_reg;
                            latch_next = 1'b1;
                            if (!cmd_reg[CMD_SEQ_BIT]) begin
                                loaded_next = 1'b0;
                            end
                        end else if (rda_s && cmd_reg[CMD_SEQ_BIT]) begin
                            addr_next = addr_reg + 8'h01;
                        end
                    end
                end
            end
            HOLD: begin
                if (!any_s) begin
                    sync_next = 1'b0;
                    state_next = ACTIVE;
                end
            end
            ACTIVE: begin
                // One idle cycle with sync released before the next strobe
                state_next = IDLE;
            end
            default: state_next = IDLE;
        endcase
        // Acknowledge window after module selection
        if (ack_wait_reg) begin
            if (ack_sync_n) begin
                ack_wait_next = 1'b0;
            end else if (ack_cnt_reg == 8'(ACK_WAIT_CYC - 1)) begin
                ack_wait_next = 1'b0;
                du_next = 1'b1;
            end else begin
                ack_cnt_next = ack_cnt_reg + 8'h01;
            end
        end
        // Step only after the data clock, so the pulse is steered by this byte's address
        if (clk_pulse_reg && cmd_reg[CMD_SEQ_BIT]) begin
            addr_next = addr_reg + 8'h01;
        end
    end

    // Output latch starts a delayed data clock pulse, gated by write mode
    always_comb begin
        dly_next = {dly_reg[6:0], latch_reg};
        clk_pulse_next = dly_reg[CLK_DELAY_CYC - 1] && cmd_reg[CMD_WRT_BIT];
    end

    always_ff @(posedge clk or negedge srst_n) begin
        if (!srst_n) begin
            state_reg <= IDLE;
            sel_reg <= 1'b0;
            loaded_reg <= 1'b0;
            du_reg <= 1'b0;
            cmd_reg <= CMD_RESET;
            addr_reg <= ADDR_RESET;
            data_reg <= DATA_RESET;
            latch_reg <= 1'b0;
            sync_reg <= 1'b0;
            ack_wait_reg <= 1'b0;
            ack_cnt_reg <= '0;
            dly_reg <= '0;
            clk_pulse_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            sel_reg <= sel_next;
            loaded_reg <= loaded_next;
            du_reg <= du_next;
            cmd_reg <= cmd_next;
            addr_reg <= addr_next;
            data_reg <= data_next;
            latch_reg <= latch_next;
            sync_reg <= sync_next;
            ack_wait_reg <= ack_wait_next;
            ack_cnt_reg <= ack_cnt_next;
            dly_reg <= dly_next;
            clk_pulse_reg <= clk_pulse_next;
        end
    end

    assign sync_reply_n = ~sync_reg;
    assign selected_flag = sel_reg;
    assign address_loaded_flop = loaded_reg;
    assign device_unavailable_flag = du_reg;
    assign mode.int_ctrl = cmd_reg[CMD_INT_HI:CMD_INT_LO];
    assign mode.addressed_access_bit = cmd_reg[CMD_ADDRESSED_ACCESS_BIT_BIT];
    assign mode.incrementing_access_bit = cmd_reg[CMD_SEQ_BIT];
    assign mode.output_direction_bit = cmd_reg[CMD_WRT_BIT];
    assign mode.read_bit = cmd_reg[CMD_RD_BIT];
    assign address_out = addr_reg;
    assign output_data = data_reg;
    assign module_data_clock = clk_pulse_reg;
    assign module_sel.module_select = addr_reg[ADDR_MOD_HI:ADDR_MOD_LO];
    assign module_sel.output_select = cmd_reg[CMD_WRT_BIT];
    assign module_sel.input_select = cmd_reg[CMD_RD_BIT];
    assign module_sel.byte_select = addr_reg[ADDR_BYTE_HI:ADDR_BYTE_LO];
    assign module_sel.group_one_clock = clk_pulse_reg && !addr_reg[ADDR_GROUP_BIT];
    assign module_sel.group_two_clock = clk_pulse_reg && addr_reg[ADDR_GROUP_BIT];
endmodule

// ==== verif/dio_bus_port_properties.sv ====
// Concurrent checks on the bus port pins
`timescale 1ns/100ps
module dio_bus_port_checker import dio_port_pkg::*; #(
    parameter logic [7:0] DEVICE_ADDRESS = 8'h01
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire strobes_s strobes_n,
    input wire logic [DATA_W-1:0] bus_data_lines,
    input wire logic module_acknowledge_n,
    input wire logic sync_reply_n,
    input wire logic selected_flag,
    input wire logic device_unavailable_flag,
    input wire mode_s mode,
    input wire logic [DATA_W-1:0] address_out,
    input wire logic [DATA_W-1:0] output_data,
    input wire module_sel_s module_sel,
    input wire logic module_data_clock
);
    logic any_strobe;
    assign any_strobe = (strobes_n != 4'hf);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_sync_has_strobe: assert property (
        $fell(sync_reply_n) |-> any_strobe && $past(any_strobe, 4))
        else $error("sync fell without a held strobe");
    a_sync_holds: assert property (
        !sync_reply_n && any_strobe |=> !sync_reply_n)
        else $error("sync released while strobe still low");
    a_addr_match: assert property (
        $fell(sync_reply_n) && !strobes_n.address_strobe
        |-> (bus_data_lines == DEVICE_ADDRESS) ##[0:2] selected_flag)
        else $error("address answered without a match");
    a_sel_needed: assert property (
        $fell(sync_reply_n) && strobes_n.address_strobe |-> selected_flag)
        else $error("strobe answered while not selected");
    a_mode_cause: assert property (
        !$stable(mode) |-> !strobes_n.command_strobe)
        else $error("mode changed without a command strobe");
    a_data_cause: assert property (
        !$stable(output_data) |-> mode.output_direction_bit && !strobes_n.write_data_strobe)
        else $error("data register changed outside a write strobe");
    a_clk_single: assert property (
        module_data_clock |=> !module_data_clock)
        else $error("data clock longer than one cycle");
    a_clk_write: assert property (
        module_data_clock |-> mode.output_direction_bit && module_sel.output_select)
        else $error("data clock outside write mode");
    a_group_one: assert property (
        module_sel.group_one_clock
        |-> module_data_clock && !address_out[ADDR_GROUP_BIT])
        else $error("group one clock with wrong group bit");
    a_unavail_cause: assert property (
        $rose(device_unavailable_flag)
        |-> module_acknowledge_n && $past(module_acknowledge_n, 50))
        else $error("unavailable flag set despite acknowledge");
endmodule

bind dio_bus_port dio_bus_port_checker #(.DEVICE_ADDRESS(DEVICE_ADDRESS)) i_chk (
    .clk, .rst_n, .strobes_n, .bus_data_lines, .module_acknowledge_n, .sync_reply_n,
    .selected_flag, .device_unavailable_flag, .mode, .address_out, .output_data,
    .module_sel, .module_data_clock);

// ==== verif/proc_bus_model.sv ====
// Processor side model: drives one strobe pattern per request, which may hold several strobes, and waits for sync
`timescale 1ns/100ps
module proc_bus_model import dio_port_pkg::*; #(
    parameter int TIMEOUT_CYC = 40
) (
    input wire logic clk,
    input wire logic go,
    input wire logic [3:0] vec,
    input wire logic [DATA_W-1:0] dat,
    input wire logic sync_reply_n,
    output strobes_s strobes_n,
    output logic [DATA_W-1:0] bus_data_lines,
    output logic done,
    output logic timed_out
);
    // Real time-out is tens of microseconds; shortened so refusals stay cheap
    int n;
    initial begin
        strobes_n = 4'hf;
        bus_data_lines = 8'h00;
        done = 1'b0;
        timed_out = 1'b0;
        forever begin
            @(posedge clk);
            if (go) begin
                bus_data_lines <= dat;
                @(posedge clk);
                strobes_n <= vec;
                n = 0;
                while (sync_reply_n !== 1'b0 && n < TIMEOUT_CYC) begin
                    @(posedge clk);
                    n++;
                end
                timed_out <= (n >= TIMEOUT_CYC);
                strobes_n <= 4'hf;
                n = 0;
                while (sync_reply_n !== 1'b1 && n < TIMEOUT_CYC) begin
                    @(posedge clk);
                    n++;
                end
                // Released lines float; inverting keeps stale data from passing
                bus_data_lines <= ~dat;
                done <= 1'b1;
                @(posedge clk);
                done <= 1'b0;
            end
        end
    end
endmodule

// ==== verif/digital_io_controller_bus_port_tb.sv ====
// Self-checking bench for the digital I/O controller bus port
`timescale 1ns/100ps
module digital_io_controller_bus_port_tb import dio_port_pkg::*;;
    typedef struct packed {
        logic [3:0] vec;
        logic [7:0] dat;
        logic ans;
        logic [2:0] sel;
        logic [7:0] exp;
    } row_s;
    // Strobe pattern, bus byte, {answered, check}, expected byte
    // Checks: 1 mode, 2 address, 3 data, 4 address step, 5 unavailable, 6 selected
    localparam logic [23:0] ROWS [35] = '{
        'h75ae01, 'hb53900, 'h75a800, 'hd12a12, 'h75a800, 'hda5ba5, 'h75a800,
        'hd25a25, 'h75a800, 'hd3cb3c, 'h75a800, 'hb60900, 'h75a800, 'hd03a03,
        'h75a800, 'hd11b11, 'hd22c00, 'h35a000, 'h733600, 'hd44000, 'h75a800,
        'hb80900, 'h75a800, 'hd07a07, 'he00800, 'h75a800, 'hd99b22, 'h75a800,
        'hb50900, 'h75a800, 'hd0fd01, 'h75a800, 'hb50900, 'h75a800, 'hd0ed00};
    logic clk, rst_n, go, ack_en, module_acknowledge_n, sync_reply_n, done, timed_out;
    logic selected_flag, address_loaded_flop, device_unavailable_flag, module_data_clock;
    logic [3:0] vec;
    logic [7:0] dat, prev, bus_data_lines, address_out, output_data;
    strobes_s strobes_n;
    mode_s mode;
    module_sel_s module_sel;
    int miscompares, n_tests;
    int pulses = 0;
    int g1 = 0;
    int g2 = 0;

    dio_bus_port #(.DEVICE_ADDRESS(8'h5a)) i_dut (.clk, .rst_n, .strobes_n, .bus_data_lines,
        .module_acknowledge_n, .sync_reply_n, .selected_flag, .address_loaded_flop,
        .device_unavailable_flag, .mode, .address_out, .output_data, .module_sel,
        .module_data_clock);
    proc_bus_model i_proc (.clk, .go, .vec, .dat, .sync_reply_n, .strobes_n,
        .bus_data_lines, .done, .timed_out);

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // Output module stand-in: acknowledges once an address is loaded
    always @(posedge clk) begin
        module_acknowledge_n <= !(ack_en && address_loaded_flop);
        pulses <= pulses + module_data_clock;
        g1 <= g1 + module_sel.group_one_clock;
        g2 <= g2 + module_sel.group_two_clock;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic run(input logic [3:0] v, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk);
        vec <= v;
        dat <= d;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        while (done !== 1'b1 && n < 300) begin
            @(posedge clk);
            n++;
        end
        if (n >= 300) chk(16'h0, 16'h1);
        #1;
    endtask

    task automatic summarize;
        $display("miscompares %0d n_tests %0d", miscompares, n_tests);
        if (miscompares == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        row_s r;
        {rst_n, go, vec, dat, prev, ack_en} = {2'b00, 4'hf, 16'h0, 1'b1};
        {miscompares, n_tests} = '0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        repeat (8) @(posedge clk);
        foreach (ROWS[i]) begin
            r = ROWS[i];
            ack_en <= !(r.sel == 3'd5 && r.exp[0]);
            run(r.vec, r.dat);
            chk(!timed_out, r.ans);
            case (r.sel)
                3'd1: chk({mode, module_sel.output_select, module_sel.input_select},
                    {r.dat[1:0], r.dat[4], r.dat[5], r.dat[6], r.dat[7], r.dat[6], r.dat[7]});
                3'd2: chk({module_sel.byte_select, module_sel.module_select, address_out},
                    {r.exp[7:5], r.exp[3:0], r.exp});
                3'd3: chk(output_data, r.exp);
                3'd4: chk(address_out, prev + 8'h01);
                3'd5: begin
                    repeat (120) @(posedge clk);
                    chk(device_unavailable_flag, r.exp[0]);
                end
                3'd6: chk(selected_flag, r.exp[0]);
                default: ;
            endcase
            prev = address_out;
        end
        chk(16'(pulses), 16'd4);
        chk({g1[7:0], g2[7:0]}, 16'h0301);
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        chk({selected_flag, sync_reply_n, mode, output_data}, 16'h4000);
        @(posedge clk);
        rst_n <= 1'b1;
        repeat (8) @(posedge clk);
        run(4'hd, 8'h55);
        chk(!timed_out, 1'b0);
        summarize();
    end

    // About twenty times the expected run length
    initial begin
        #100000;
        chk(16'h0, 16'h1);
        summarize();
    end
endmodule
